/* File: ddac_i2c.sv */
`timescale 1ns/1ps
// How it works
// R1: Bus address is 00011 followed by the two address-select pins.
// R2: Select pin high gives a 1 bit, low gives 0; four addresses.
// R3: Start is data falling while clock high; detected here.
// R4: Matching address acknowledged by holding data low in ninth pulse.
// R5: Bytes are eight bits MSB first plus one acknowledge bit.
// R6: Data changes only while clock low, except start and stop.
// R7: Master ends a read with not-acknowledge then stop.
// R8: Write is address, command byte, high data, low data, stop.
// R9: Address byte and all three written bytes are acknowledged.
// R10: Readback begins with a write of the control byte.
// R11: Repeated start and read address, then device sends register bytes.
// R12: Readback continues until not-acknowledge and stop.
// R13: Both channels selected means channel A is returned first.
// R14: A two bytes, four spare bytes, then B two bytes.
// R15: After B the readback wraps to channel A.
// R16: Command 0100 sets power modes from the low eight frame bits.
// R17: Bits 7:6 channel B power, 5:2 ones, 1:0 channel A power.
// R18: Power codes: normal, 1k, 100k, three-state; nonzero shuts channel down.
// R19: Power-down keeps DAC register and still accepts updates.
// R20: Command 0001 with strobe low updates input and DAC on 24th clock.
// R21: Strobe high keeps DAC; later strobe fall copies inputs to DAC.
// R22: Frame is command 23:20, address 19:16, 12-bit code in 15:4.
// R23: Command 0011 writes input and DAC regardless of strobe.
// R24: Command 0010 copies input registers to DAC registers of addressed channels.
// R25: Masked channels ignore the load strobe pin; the code masks only its fall, not a 0001 write with it low.
// R26: Readback code left-aligned, low nibble of second byte zero.
// R27: Reserved commands are acknowledged but change nothing.
module ddac_i2c
    import ddac_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_sel_pin0,
    input wire logic addr_sel_pin1,
    input wire logic load_strobe_n,
    output logic [11:0] dac_a_code,
    output logic [11:0] dac_b_code,
    output logic [11:0] input_a_code,
    output logic [11:0] input_b_code,
    output logic [1:0] chan_a_power,
    output logic [1:0] chan_b_power,
    output logic chan_a_shutdown,
    output logic chan_b_shutdown,
    output logic [1:0] load_mask
);
    import ddac_pkg::*;

    typedef enum logic [2:0] {
        DDAC_IDLE, DDAC_ADDR, DDAC_WACK, DDAC_WDATA, DDAC_RDATA, DDAC_RACK, DDAC_IGNORE
    } ddac_state_t;

    logic scl_s, sda_s, ldn_s, sel0_s, sel1_s;
    logic scl_d, sda_d, ldn_d;
    logic scl_rise, scl_fall, start_det, stop_det, ld_fall;

    ddac_sync #(.WIDTH(5)) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in({scl_in, sda_in, load_strobe_n, addr_sel_pin0, addr_sel_pin1}),
        .sync_out({scl_s, sda_s, ldn_s, sel0_s, sel1_s})
    );
    // Edge history of synchronised pins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            ldn_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            ldn_d <= ldn_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s; // [R3]
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;
    assign ld_fall = ldn_d && !ldn_s;

    ddac_state_t state, next_state;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [1:0] bytecnt, next_bytecnt;
    logic [23:0] frame, next_frame;
    logic [2:0] rbptr, next_rbptr;
    logic next_sda_out, next_sda_oe;
    logic frame_done;
    logic [6:0] my_addr;
    logic [7:0] rb_byte;

    assign my_addr = {ADDR_HI, sel1_s, sel0_s}; // [R1] [R2]

    // Readback byte for current pointer, code left-aligned
    always_comb begin
        case (rbptr)
            3'h0: rb_byte = input_a_code[11:4];
            3'h1: rb_byte = {input_a_code[3:0], 4'h0}; // [R26]
            RB_B_FIRST: rb_byte = input_b_code[11:4]; // [R14]
            RB_LAST: rb_byte = {input_b_code[3:0], 4'h0};
            default: rb_byte = 8'h00;
        endcase
    end

    // Bus protocol next-state: bits shift on clock rise, drive on clock fall
    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_bytecnt = bytecnt;
        next_frame = frame;
        next_rbptr = rbptr;
        next_sda_out = sda_out;
        next_sda_oe = sda_oe;
        frame_done = 1'b0;
        if (start_det) begin
            next_state = DDAC_ADDR; // [R3]
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_det) begin
            next_state = DDAC_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                DDAC_ADDR, DDAC_WDATA: begin
                    if (scl_rise && bitcnt < 4'h8) begin
                        next_shreg = {shreg[6:0], sda_s}; // [R5] [R6]
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        next_bitcnt = 4'h0;
                        if (state == DDAC_ADDR) begin
                            if (shreg[7:1] == my_addr) begin
                                next_sda_out = 1'b0; // [R4] [R9]
                                next_sda_oe = 1'b1;
                                next_state = DDAC_WACK;
                                next_bytecnt = 2'h0;
                                // Control byte was the last byte shifted in; both channels start at A [R13] [R11]
                                if (shreg[0])
                                    next_rbptr = (frame[0] || !frame[3]) ? 3'h0 : RB_B_FIRST;
                                next_shreg = shreg;
                            end else begin
                                next_state = DDAC_IGNORE;
                            end
                        end else begin
                            next_frame = {frame[15:0], shreg}; // [R22]
                            next_sda_out = 1'b0; // [R9] [R27]
                            next_sda_oe = 1'b1;
                            next_state = DDAC_WACK;
                            next_bytecnt = bytecnt + 2'h1;
                            frame_done = (bytecnt == 2'(FRAME_BYTES - 1)); // [R8] [R20]
                        end
                    end
                end
                DDAC_WACK: begin
                    if (scl_fall) begin
                        // An address ack, or the ack of a fourth data byte, leaves bytecnt at zero; shreg[0] then picks the direction
                        if (shreg[0] && bytecnt == 2'h0) begin
                            next_state = DDAC_RDATA;
                            next_sda_out = rb_byte[7];
                            next_sda_oe = 1'b1;
                            next_shreg = {rb_byte[6:0], 1'b0};
                            next_bitcnt = 4'h1;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = DDAC_WDATA;
                        end
                    end
                end
                DDAC_RDATA: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            next_sda_oe = 1'b0;
                            next_state = DDAC_RACK;
                        end else begin
                            next_sda_out = shreg[7]; // [R5]
                            next_shreg = {shreg[6:0], 1'b0};
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                DDAC_RACK: begin
                    if (scl_rise) begin
                        next_rbptr = (rbptr == RB_LAST) ? 3'h0 : rbptr + 3'h1; // [R14] [R15]
                        next_state = sda_s ? DDAC_IGNORE : DDAC_RACK; // [R7] [R12]
                        next_bitcnt = 4'h0;
                    end else if (scl_fall && bitcnt == 4'h0) begin
                        next_state = DDAC_RDATA;
                        next_sda_out = rb_byte[7];
                        next_sda_oe = 1'b1;
                        next_shreg = {rb_byte[6:0], 1'b0};
                        next_bitcnt = 4'h1;
                    end
                end
                DDAC_IGNORE, DDAC_IDLE: next_sda_oe = 1'b0;
                default: next_state = DDAC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= DDAC_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            bytecnt <= 2'h0;
            frame <= 24'h000000;
            rbptr <= 3'h0;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            bytecnt <= next_bytecnt;
            frame <= next_frame;
            rbptr <= next_rbptr;
            sda_out <= next_sda_out;
            sda_oe <= next_sda_oe;
        end
    end

    // Register bank next values, per channel
    logic [11:0] next_in [2];
    logic [11:0] next_dac [2];
    logic [1:0] next_pwr [2];
    logic [1:0] next_mask;
    logic [11:0] in_r [2];
    logic [11:0] dac_r [2];
    logic [1:0] pwr_r [2];
    logic [3:0] cmd;
    logic [1:0] sel;

    assign cmd = next_frame[CMD_MSB:CMD_LSB];
    assign sel = {next_frame[ADR_B_BIT], next_frame[ADR_A_BIT]};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            // DAC register keeps accepting updates in power-down [R19]
            always_comb begin
                next_in[ch] = in_r[ch];
                next_dac[ch] = dac_r[ch];
                next_pwr[ch] = pwr_r[ch];
                if (frame_done) begin
                    case (cmd)
                        CMD_WR_IN: if (sel[ch]) begin
                            next_in[ch] = next_frame[CODE_MSB:CODE_LSB];
                            if (!ldn_s)
                                next_dac[ch] = next_frame[CODE_MSB:CODE_LSB]; // [R20]
                        end
                        CMD_UPD: if (sel[ch])
                            next_dac[ch] = in_r[ch]; // [R24]
                        CMD_WR_UPD: if (sel[ch]) begin
                            next_in[ch] = next_frame[CODE_MSB:CODE_LSB]; // [R23]
                            next_dac[ch] = next_frame[CODE_MSB:CODE_LSB];
                        end
                        CMD_PWR: next_pwr[ch] = (ch == 0) ? next_frame[1:0] : next_frame[7:6]; // [R16] [R17]
                        default: ; // [R27]
                    endcase
                end else if (ld_fall && !load_mask[ch]) begin
                    next_dac[ch] = in_r[ch]; // [R21] [R25]
                end
            end

            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    in_r[ch] <= CODE_RST;
                    dac_r[ch] <= CODE_RST;
                    pwr_r[ch] <= PWR_RST;
                end else begin
                    in_r[ch] <= next_in[ch];
                    dac_r[ch] <= next_dac[ch];
                    pwr_r[ch] <= next_pwr[ch];
                end
            end
        end
    endgenerate

    // Mask register from command 0101: bit 3 channel B, bit 0 channel A
    always_comb begin
        next_mask = load_mask;
        if (frame_done && cmd == CMD_MASK)
            next_mask = {next_frame[3], next_frame[0]};
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            load_mask <= 2'h0;
        else
            load_mask <= next_mask;
    end

    assign input_a_code = in_r[0];
    assign input_b_code = in_r[1];
    assign dac_a_code = dac_r[0];
    assign dac_b_code = dac_r[1];
    assign chan_a_power = pwr_r[0];
    assign chan_b_power = pwr_r[1];
    assign chan_a_shutdown = (pwr_r[0] != PWR_NORMAL); // [R18]
    assign chan_b_shutdown = (pwr_r[1] != PWR_NORMAL);

    // Ack slot: device holds data low after a matching address
    property ack_after_addr_p;
        @(posedge core_clk) disable iff (!arst_n)
        (state == DDAC_ADDR && scl_fall && bitcnt == 4'h8 && shreg[7:1] == my_addr && !start_det && !stop_det)
        |=> (sda_oe && !sda_out);
    endproperty
    addr_ack_a: assert property (ack_after_addr_p) else $error("address not acknowledged"); // [R4]

    foreign_addr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state == DDAC_IGNORE) |-> !sda_oe) else $error("drove bus when not addressed"); // [R1]

    sequence wr_upd_frame_s;
        frame_done && cmd == CMD_WR_UPD && sel[0];
    endsequence
    wr_upd_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        wr_upd_frame_s |=> (dac_r[0] == in_r[0])) else $error("write-update mismatch"); // [R23]

    upd_cmd_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (frame_done && cmd == CMD_UPD && sel[1]) |=> (dac_r[1] == $past(in_r[1]))) else $error("update failed"); // [R24]

    pwr_cmd_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (frame_done && cmd == CMD_PWR) |=> (pwr_r[1] == $past(next_frame[7:6]))) else $error("power field wrong"); // [R17]

    shutdown_map_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        chan_a_shutdown == (chan_a_power != 2'h0)) else $error("shutdown flag wrong"); // [R18]

    masked_ld_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (ld_fall && load_mask[0] && !frame_done) |=> $stable(dac_r[0])) else $error("masked channel loaded"); // [R25]

    rsvd_cmd_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (frame_done && cmd[3] && !ld_fall) |=> ($stable(in_r[0]) && $stable(pwr_r[0]))) else $error("reserved changed"); // [R27]

    rb_wrap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state == DDAC_RACK && scl_rise && rbptr == RB_LAST && !start_det && !stop_det) |=> rbptr == 3'h0)
        else $error("readback did not wrap"); // [R15]
endmodule

/* File: ddac_pkg.sv */
package ddac_pkg;
    // Bus address upper five bits
    localparam logic [4:0] ADDR_HI = 5'h03;
    // Frame field positions
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADR_B_BIT = 19;
    localparam int ADR_A_BIT = 16;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 4;
    localparam int FRAME_BYTES = 3;
    // Command codes
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_IN = 4'h1;
    localparam logic [3:0] CMD_UPD = 4'h2;
    localparam logic [3:0] CMD_WR_UPD = 4'h3;
    localparam logic [3:0] CMD_PWR = 4'h4;
    localparam logic [3:0] CMD_MASK = 4'h5;
    // Readback cycle: two bytes A, four spare bytes, two bytes B
    localparam logic [2:0] RB_LAST = 3'h7;
    localparam logic [2:0] RB_B_FIRST = 3'h6;
    // Reset values
    localparam logic [11:0] CODE_RST = 12'h000;
    localparam logic [1:0] PWR_RST = 2'h0;
    // Power field encodings
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_1K = 2'h1;
    localparam logic [1:0] PWR_100K = 2'h2;
    localparam logic [1:0] PWR_TRI = 2'h3;
    // Link clock timing
    localparam real SCL_MIN_NS = 125.0;
    localparam real CLK_NS = 5.0;
    localparam int SCL_MIN_CYC = int'(SCL_MIN_NS / CLK_NS);
endpackage

/* File: ddac_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs, one bit per lane
module ddac_sync #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* File: ddac_master.sv */
`timescale 1ns/1ps
// Behavioural bus master: pulls the data line low or lets the pull-up take it
module ddac_master (
    input wire logic core_clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_low
);
    // Bus idles high on both lines
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // All line changes land just after a core clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Start or repeated start: data falls while the clock is high
    task automatic do_start();
        sda_low <= 1'b0;
        tick(6);
        scl <= 1'b1;
        tick(6);
        sda_low <= 1'b1;
        tick(6);
        scl <= 1'b0;
        tick(1);
    endtask
    // One bit: set while clock low, held through the high phase
    task automatic bit_io(input logic b, output logic r);
        tick(6);
        sda_low <= ~b;
        tick(7);
        scl <= 1'b1;
        tick(6);
        r = sda_bus;
        tick(6);
        scl <= 1'b0;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_bit, ack);
    endtask
    // Stop: data rises while clock high; a read is ended by a released ack first
    task automatic do_stop();
        tick(6);
        sda_low <= 1'b1;
        tick(7);
        scl <= 1'b1;
        tick(6);
        sda_low <= 1'b0;
        tick(12);
    endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    import ddac_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic addr_sel_pin0 = 1'b0;
    logic addr_sel_pin1 = 1'b0;
    logic load_strobe_n = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, sda_bus, ack;
    logic [11:0] dac_a_code, dac_b_code, input_a_code, input_b_code;
    logic [11:0] ia, ib, ea, eb;
    logic [1:0] chan_a_power, chan_b_power, load_mask;
    logic chan_a_shutdown, chan_b_shutdown;
    logic [7:0] rx;
    int err_count = 0;
    int cmp_count = 0;
    int seed = 74;

    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;
    // Open-drain data line with pull-up: low if either side pulls
    assign sda_bus = ~(sda_low | (sda_oe & ~sda_out));

    ddac_i2c u_dut (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin0(addr_sel_pin0), .addr_sel_pin1(addr_sel_pin1),
        .load_strobe_n(load_strobe_n), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
        .input_a_code(input_a_code), .input_b_code(input_b_code), .chan_a_power(chan_a_power),
        .chan_b_power(chan_b_power), .chan_a_shutdown(chan_a_shutdown), .chan_b_shutdown(chan_b_shutdown),
        .load_mask(load_mask));
    ddac_master u_master (.core_clk(core_clk), .sda_bus(sda_bus), .scl(scl), .sda_low(sda_low));

    // Compare one value, count it, report a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Single exit point for normal end and watchdog
    task automatic give_verdict();
        $display("Summary: %0d comparisons, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Own bus address from the pins
    function automatic logic [7:0] addr_byte(input logic rw);
        return {ADDR_HI, addr_sel_pin1, addr_sel_pin0, rw};
    endfunction
    // Register effect of a write frame; 0001 passes through only while the strobe is low
    function automatic void predict(input logic [3:0] cmd, input logic [3:0] adr, input logic [11:0] code);
        if (cmd == CMD_WR_IN || cmd == CMD_WR_UPD) begin
            if (adr[0]) ia = code;
            if (adr[3]) ib = code;
        end
        if (cmd == CMD_UPD || cmd == CMD_WR_UPD || (cmd == CMD_WR_IN && !load_strobe_n)) begin
            if (adr[0]) ea = ia;
            if (adr[3]) eb = ib;
        end
    endfunction
    // Readback byte n of the cycle A hi, A lo, four spares, B hi, B lo
    function automatic logic [7:0] rb_byte(input int n);
        logic [11:0] r;
        r = (n % 8 < 4) ? ia : ib;
        return (n % 2 == 0) ? r[11:4] : {r[3:0], 4'h0};
    endfunction
    task automatic check_regs();
        check({input_a_code, input_b_code}, {ia, ib}, "input codes");
        check({dac_a_code, dac_b_code}, {ea, eb}, "dac codes");
    endtask
    // Whole write frame; the address and all three bytes must be acknowledged
    task automatic frame(input logic [3:0] cmd, input logic [3:0] adr, input logic [15:0] data);
        logic [23:0] f;
        f = {cmd, adr, data};
        u_master.do_start();
        u_master.xfer(addr_byte(1'b0), 1'b1, rx, ack);
        check(ack, 1'b0, "address ack");
        for (int i = 2; i >= 0; i--) begin
            u_master.xfer(f[8*i +: 8], 1'b1, rx, ack);
            check(ack, 1'b0, "data ack");
        end
        u_master.do_stop();
    endtask
    // Random don't-care nibble makes sure the low bits are ignored
    // Prediction runs after the frame, so a strobe change just before the call has settled
    task automatic wr(input logic [3:0] cmd, input logic [3:0] adr, input logic [11:0] code);
        frame(cmd, adr, {code, 4'($random(seed))});
        predict(cmd, adr, code);
        check_regs();
    endtask

    // Main sequence
    initial begin
        {ia, ib, ea, eb} = '0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        check_regs();
        check({sda_oe, chan_a_power, chan_b_power, load_mask}, 7'h00, "reset state");
        // Every pin setting: one foreign address ignored, then own address accepted
        for (int p = 0; p < 4; p++) begin
            addr_sel_pin0 <= p[0];
            addr_sel_pin1 <= p[1];
            @(posedge core_clk);
            u_master.do_start();
            u_master.xfer({ADDR_HI ^ 5'(p[0]), p[1] ^ ~p[0], p[0], 1'b0}, 1'b1, rx, ack);
            check(ack, 1'b1, "foreign address");
            u_master.do_stop();
            wr(CMD_WR_UPD, 4'h9, (p == 0) ? 12'hFFF : 12'($random(seed)));
        end
        wr(CMD_WR_IN, 4'h1, 12'($random(seed)));
        load_strobe_n <= 1'b1;
        wr(CMD_WR_IN, 4'h9, 12'($random(seed)));
        wr(CMD_WR_IN, 4'h8, 12'h000);
        load_strobe_n <= 1'b0;
        ea = ia;
        eb = ib;
        repeat (10) @(posedge core_clk);
        check_regs();
        load_strobe_n <= 1'b1;
        wr(CMD_WR_UPD, 4'h8, 12'($random(seed)));
        wr(CMD_WR_IN, 4'h1, 12'($random(seed)));
        wr(CMD_UPD, 4'h1, 12'($random(seed)));
        // Mask channel A, then a strobe fall may only move channel B
        frame(CMD_MASK, 4'h0, 16'h0001);
        check(load_mask, 2'h1, "mask");
        wr(CMD_WR_IN, 4'h9, 12'($random(seed)));
        load_strobe_n <= 1'b0;
        eb = ib;
        repeat (10) @(posedge core_clk);
        check_regs();
        load_strobe_n <= 1'b1;
        frame(CMD_MASK, 4'h0, 16'h0000);
        // Every power encoding on both channels, address nibble random
        for (int m = 0; m < 4; m++) begin
            frame(CMD_PWR, 4'($random(seed)), {8'($random(seed)), 2'(3 - m), 4'hF, 2'(m)});
            check({chan_b_power, chan_a_power}, {2'(3 - m), 2'(m)}, "power");
            check({chan_b_shutdown, chan_a_shutdown}, {m != 3, m != 0}, "shutdown");
        end
        wr(CMD_WR_UPD, 4'h1, 12'($random(seed)));
        check(chan_a_power, PWR_TRI, "power kept");
        // No-op and reserved codes 8 to 15 must leave everything alone
        for (int k = 7; k < 16; k++) begin
            frame(4'(k == 7 ? 0 : k), 4'h9, 16'($random(seed)));
            check_regs();
            check({chan_b_power, chan_a_power, load_mask}, {PWR_NORMAL, PWR_TRI, 2'h0}, "state kept");
        end
        // Readback of both channels: control byte, repeated start, ten bytes, NACK, stop
        u_master.do_start();
        u_master.xfer(addr_byte(1'b0), 1'b1, rx, ack);
        u_master.xfer({CMD_NOP, 4'h9}, 1'b1, rx, ack);
        check(ack, 1'b0, "control ack");
        u_master.do_start();
        u_master.xfer(addr_byte(1'b1), 1'b1, rx, ack);
        check(ack, 1'b0, "read address ack");
        for (int n = 0; n < 10; n++) begin
            u_master.xfer(8'hFF, n == 9, rx, ack);
            if (n < 2 || n > 5) check(rx, rb_byte(n), "readback");
        end
        u_master.do_stop();
        check(sda_oe, 1'b0, "bus released");
        give_verdict();
    end

    // Watchdog well beyond the expected run of about 30000 cycles
    initial begin
        #300000;
        err_count++;
        give_verdict();
    end
endmodule
